// ### csc_map.svh
// csc_map.svh: offsets, field positions and reset values of the cache
// and scratchpad controller; definitions only
`ifndef CSC_MAP_SVH
`define CSC_MAP_SVH
`define CSC_CTRL_OFS 12'h000
`define CSC_STAT_OFS 12'h004
`define CSC_CTRL_RST 2'h3
`define CSC_SET_BITS 8
`define CSC_IDX_LSB 4
`define CSC_IDX_MSB 11
`define CSC_TAG_LSB 10
`define CSC_TAG_W 22
`define CSC_SPR_W 20
`define CSC_LAST_WORD 2'h3
`define CSC_ALL_WORDS 4'hF
`endif

// ### csc_pkg.sv
// csc_pkg: types shared by the cache and scratchpad controller
// assumes csc_map.svh is on the include path
`include "csc_map.svh"
package csc_pkg;
	typedef enum logic [4:0] {
		CSC_IDLE = 5'h01,
		CSC_LOOK = 5'h02,
		CSC_CMP = 5'h04,
		CSC_MEMR = 5'h08,
		CSC_MEMW = 5'h10
	} csc_st_e;
	typedef struct packed {
		logic vld;
		logic we;
		logic uncached;
		logic [3:0] be;
		logic [31:0] vaddr;
		logic [31:0] paddr;
		logic [31:0] wdata;
	} csc_req_s;
	typedef struct packed {
		logic rdy;
		logic ack;
		logic [31:0] rdata;
	} csc_rsp_s;
	typedef struct packed {
		logic vld;
		logic side;
		logic lock;
		logic [31:0] vaddr;
		logic [31:0] paddr;
	} csc_cm_s;
	typedef struct packed {
		logic vld;
		logic we;
		logic burst;
		logic [3:0] be;
		logic [31:0] addr;
		logic [31:0] wdata;
	} csc_mem_req_s;
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} csc_mem_rsp_s;
	typedef struct packed {
		logic idx_vld;
		logic [`CSC_SPR_W-1:0] idx;
		logic tag_vld;
		logic [`CSC_TAG_W-1:0] tag;
		logic we;
		logic [3:0] be;
		logic [31:0] wdata;
	} csc_spr_req_s;
	typedef struct packed {
		logic hit;
		logic [31:0] rdata;
	} csc_spr_rsp_s;
	typedef struct packed {
		logic [`CSC_TAG_W-1:0] ptag;
		logic [3:0] vld;
		logic lock;
		logic frep;
	} csc_tag_s;
endpackage : csc_pkg

// ### csc_ctrl.sv
// csc_ctrl: instruction and data cache controller with scratchpad port
// assumes one clock, pipeline holds valid/ready, bus unit bursts wrapped
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "csc_map.svh"

module csc_ctrl #(
	parameter int I_WAYS = 4,
	parameter int D_WAYS = 4,
	parameter bit I_EN = 1'b1,
	parameter bit D_EN = 1'b1,
	parameter bit I_SPR = 1'b0,
	parameter bit D_SPR = 1'b0
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pipeline, index 0 fetch, index 1 load/store
	input wire csc_pkg::csc_req_s [1:0] cpu_req,
	output wire csc_pkg::csc_rsp_s [1:0] cpu_rsp,
	input wire csc_pkg::csc_cm_s cm_req,
	output wire logic [1:0] cm_ack,
	// bus interface unit
	output csc_pkg::csc_mem_req_s mem_req,
	input wire csc_pkg::csc_mem_rsp_s mem_rsp,
	// scratchpads
	output wire csc_pkg::csc_spr_req_s [1:0] spr_req,
	input wire csc_pkg::csc_spr_rsp_s [1:0] spr_rsp
);
	import csc_pkg::*;

	localparam int S = 1 << `CSC_SET_BITS;

	function automatic logic [3:0] csc_victim(input logic [3:0] elig,
		input logic [3:0] inv, input logic [3:0] frp);
		logic [3:0] v;
		v = '0;
		for (int w = 3; w >= 0; w--) begin
			if (elig[w])
				v = {2'b01, w[1:0]};
		end
		for (int w = 3; w >= 0; w--) begin
			if (elig[w] && !frp[w])
				v = {2'b01, w[1:0]};
		end
		for (int w = 3; w >= 0; w--) begin
			if (elig[w] && inv[w])
				v = {2'b01, w[1:0]};
		end
		v[3] = v[2] && ((elig & ~frp) == 4'h0);
		return v;
	endfunction : csc_victim

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	logic [1:0] ctrl_q;
	logic [1:0] own_q;
	logic [1:0] busy;
	logic [1:0] filling;
	wire apb_acc = psel & penable & ~pready;
	wire hit_ctrl = paddr == `CSC_CTRL_OFS;
	wire hit_stat = paddr == `CSC_STAT_OFS;
	wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_q} :
		{26'h0, own_q, filling, busy};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			ctrl_q <= `CSC_CTRL_RST;
		end else begin
			pready <= apb_acc;
			pslverr <= apb_acc & ~hit_ctrl & ~hit_stat;
			prdata <= (apb_acc & ~pwrite & (hit_ctrl | hit_stat)) ?
				rd_mux : 32'h0;
			// write lands on the completing edge, with pready high
			if (psel & penable & pready & pwrite & hit_ctrl)
				ctrl_q <= pwdata[1:0];
		end
	end

	// ------------------------------------------------------------
	// memory port arbiter
	// ------------------------------------------------------------
	csc_mem_req_s [1:0] sreq;
	logic [1:0] mcnt_q;
	wire mack = mem_rsp.ack & mem_req.vld;
	wire mlast = mack & (~mem_req.burst | mcnt_q == `CSC_LAST_WORD);
	wire gnt_d = own_q == 2'h0 & sreq[1].vld;
	wire gnt_i = own_q == 2'h0 & ~sreq[1].vld & sreq[0].vld;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_q <= 2'h0;
			mcnt_q <= 2'h0;
			mem_req <= '0;
		end else if (mlast) begin
			own_q <= 2'h0;
			mcnt_q <= 2'h0;
			mem_req <= '0;
		end else begin
			if (mack)
				mcnt_q <= mcnt_q + 2'h1;
			if (gnt_d | gnt_i)
				own_q <= {gnt_d, gnt_i};
			if (gnt_d | gnt_i)
				mem_req <= gnt_d ? sreq[1] : sreq[0];
		end
	end

	// ------------------------------------------------------------
	// per cache side
	// ------------------------------------------------------------
	// separate paths
	for (genvar c = 0; c < 2; c++) begin : g_side
		localparam int W = (c == 0) ? I_WAYS : D_WAYS;
		localparam bit SP = (c == 0) ? I_SPR : D_SPR;
		localparam int CW = SP ? W - 1 : W;
		csc_st_e st_q;
		csc_st_e st_d;
		csc_req_s r_q;
		csc_rsp_s rsp_q;
		csc_spr_req_s spr_q;
		csc_tag_s tg [W][S];
		logic [31:0] dat [W][S*4];
		logic [31:0] fb_q [4];
		logic [3:0] fbv_q;
		logic fact_q;
		logic falloc_q;
		logic fclr_q;
		logic [1:0] fway_q;
		logic [1:0] fptr_q;
		logic [27:0] fline_q;
		logic [`CSC_SET_BITS-1:0] fidx_q;
		logic cmack_q;
		logic [3:0] hitv;
		logic [3:0] cmhit;
		logic [3:0] elig;
		logic [3:0] inv;
		logic [3:0] frp;
		logic [31:0] hdat;
		logic ack_d;
		logic [31:0] dat_d;
		logic fstart;
		logic whit;
		wire en = ctrl_q[c] & ((c == 0) ? I_EN : D_EN);
		wire wr = (c == 1) & r_q.we;
		wire [`CSC_SET_BITS-1:0] idx = r_q.vaddr[`CSC_IDX_MSB:`CSC_IDX_LSB];
		wire [1:0] wrd = r_q.vaddr[3:2];
		wire [`CSC_TAG_W-1:0] ptag = r_q.paddr[31:`CSC_TAG_LSB];
		wire [`CSC_SET_BITS-1:0] cidx = cm_req.vaddr[`CSC_IDX_MSB:`CSC_IDX_LSB];
		wire ack_c = mack & own_q[c];
		wire last_c = mlast & own_q[c];
		wire take = st_q == CSC_IDLE & cpu_req[c].vld & rsp_q.rdy;
		wire cm_take = st_q == CSC_IDLE & cm_req.vld & cm_req.side == c &
			~take & ~cmack_q & ~fact_q;
		wire hit = ~r_q.uncached & |hitv;
		wire sphit = SP & ~r_q.uncached & spr_rsp[c].hit;
		wire same = fact_q & r_q.paddr[31:4] == fline_q;
		wire fbok = same & (fbv_q[wrd] | (ack_c & fptr_q == wrd));
		wire [31:0] fbdat = fbv_q[wrd] ? fb_q[wrd] : mem_rsp.rdata;
		wire [3:0] vict = csc_victim(elig, inv, frp);

		for (genvar w = 0; w < 4; w++) begin : g_way
			if (w < CW) begin : g_c
				assign hitv[w] = en & tg[w][idx].ptag == ptag &
					tg[w][idx].vld[wrd];
				assign cmhit[w] = tg[w][cidx].ptag ==
					cm_req.paddr[31:`CSC_TAG_LSB] & |tg[w][cidx].vld;
				assign elig[w] = en & ~tg[w][idx].lock;
				assign inv[w] = tg[w][idx].vld == 4'h0;
				assign frp[w] = tg[w][idx].frep;
			end else begin : g_n
				assign hitv[w] = 1'b0;
				assign cmhit[w] = 1'b0;
				assign elig[w] = 1'b0;
				assign inv[w] = 1'b0;
				assign frp[w] = 1'b0;
			end
		end

		always_comb begin
			hdat = 32'h0;
			for (int w = 0; w < CW; w++) begin
				if (hitv[w])
					hdat = hdat | dat[w][{idx, wrd}];
			end
		end

		always_comb begin
			st_d = st_q;
			ack_d = 1'b0;
			dat_d = 32'h0;
			fstart = 1'b0;
			whit = 1'b0;
			case (st_q)
				CSC_IDLE: begin
					if (take)
						st_d = CSC_LOOK;
				end
				CSC_LOOK: begin
					if (!((wr | r_q.uncached) & fact_q))
						st_d = CSC_CMP;
				end
				CSC_CMP: begin
					if (r_q.uncached) begin
						st_d = wr ? CSC_MEMW : CSC_MEMR;
					end else if (sphit) begin
						st_d = CSC_IDLE;
						ack_d = 1'b1;
						dat_d = spr_rsp[c].rdata;
					end else if (wr) begin
						st_d = CSC_MEMW;
						whit = hit;
					end else if (hit) begin
						st_d = CSC_IDLE;
						ack_d = 1'b1;
						dat_d = hdat;
					end else if (fbok) begin
						st_d = CSC_IDLE;
						ack_d = 1'b1;
						dat_d = fbdat;
					end else if (!fact_q) begin
						fstart = 1'b1;
					end
				end
				CSC_MEMR, CSC_MEMW: begin
					if (last_c) begin
						st_d = CSC_IDLE;
						ack_d = 1'b1;
						dat_d = mem_rsp.rdata;
					end
				end
				default: st_d = CSC_IDLE;
			endcase
		end

		assign sreq[c] = '{vld: st_q == CSC_MEMR | st_q == CSC_MEMW | fact_q,
			we: st_q == CSC_MEMW, burst: fact_q,
			be: st_q == CSC_MEMW ? r_q.be : `CSC_ALL_WORDS,
			addr: fact_q ? {fline_q, fptr_q, 2'b00} : r_q.paddr,
			wdata: r_q.wdata};
		assign cpu_rsp[c] = rsp_q;
		assign spr_req[c] = spr_q;
		assign cm_ack[c] = cmack_q;
		assign busy[c] = st_q != CSC_IDLE;
		assign filling[c] = fact_q;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				st_q <= CSC_IDLE;
				r_q <= '0;
				rsp_q <= '0;
				cmack_q <= 1'b0;
			end else begin
				st_q <= st_d;
				if (take)
					r_q <= cpu_req[c];
				rsp_q <= '{rdy: st_d == CSC_IDLE, ack: ack_d, rdata: dat_d};
				cmack_q <= cm_take;
			end
		end

		// index, then tag, hit in second cycle
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				spr_q <= '0;
			end else begin
				spr_q.idx_vld <= SP & take;
				if (take)
					spr_q.idx <= cpu_req[c].vaddr[`CSC_SPR_W-1:0];
				spr_q.tag_vld <= SP & st_d == CSC_CMP;
				spr_q.tag <= ptag;
				spr_q.we <= SP & wr & ~r_q.uncached & st_d == CSC_CMP &
					st_q == CSC_LOOK;
				spr_q.be <= r_q.be;
				spr_q.wdata <= r_q.wdata;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				fact_q <= 1'b0;
				fbv_q <= 4'h0;
				fptr_q <= 2'h0;
				fline_q <= '0;
				fidx_q <= '0;
				{fclr_q, falloc_q, fway_q} <= 4'h0;
				fb_q <= '{default: 32'h0};
			end else if (fstart) begin
				fact_q <= 1'b1;
				fptr_q <= wrd;
				fline_q <= r_q.paddr[31:4];
				fidx_q <= idx;
				{fclr_q, falloc_q, fway_q} <= vict;
			end else if (ack_c & fact_q) begin
				fb_q[fptr_q] <= mem_rsp.rdata;
				fbv_q[fptr_q] <= ~last_c;
				fptr_q <= fptr_q + 2'h1;
				if (last_c) begin
					fact_q <= 1'b0;
					fbv_q <= 4'h0;
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				for (int w = 0; w < W; w++) begin
					for (int s = 0; s < S; s++) begin
						tg[w][s] <= '0;
					end
				end
			end else if (cm_take) begin
				for (int w = 0; w < W; w++) begin
					if (cmhit[w])
						tg[w][cidx].lock <= cm_req.lock;
				end
			end else if (last_c & fact_q & falloc_q) begin
				for (int w = 0; w < W; w++) begin
					if (w == int'(fway_q))
						tg[w][fidx_q] <= '{ptag: fline_q[27:6],
							vld: `CSC_ALL_WORDS, lock: 1'b0, frep: 1'b1};
					else if (fclr_q)
						tg[w][fidx_q].frep <= 1'b0;
				end
			end
		end

		always_ff @(posedge pclk) begin
			for (int w = 0; w < CW; w++) begin
				// store hit updates locked lines too
				for (int b = 0; b < 4; b++) begin
					if (whit & hitv[w] & r_q.be[b])
						dat[w][{idx, wrd}][b*8 +: 8] <= r_q.wdata[b*8 +: 8];
				end
				if (last_c & fact_q & falloc_q & w == int'(fway_q)) begin
					for (int k = 0; k < 4; k++) begin
						dat[w][{fidx_q, k[1:0]}] <= (k[1:0] == fptr_q) ?
							mem_rsp.rdata : fb_q[k];
					end
				end
			end
		end
	end
endmodule : csc_ctrl
`default_nettype wire

// ### csc_ctrl_monitor.sv
// csc_ctrl_monitor: port assertions for the cache controller
// assumes a bind into csc_ctrl with the data scratchpad fitted
`timescale 1ns/1ns
`default_nettype none
module csc_ctrl_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// pipeline
	input wire csc_pkg::csc_req_s [1:0] cpu_req,
	input wire csc_pkg::csc_rsp_s [1:0] cpu_rsp,
	input wire csc_pkg::csc_cm_s cm_req,
	input wire logic [1:0] cm_ack,
	// bus unit and scratchpads
	input wire csc_pkg::csc_mem_req_s mem_req,
	input wire csc_pkg::csc_mem_rsp_s mem_rsp,
	input wire csc_pkg::csc_spr_rsp_s [1:0] spr_rsp,
	input wire csc_pkg::csc_spr_req_s [1:0] spr_req
);
	import csc_pkg::*;
	logic [31:0] va_q;
	logic [31:0] pa_q;
	wire tk = cpu_req[1].vld && cpu_rsp[1].rdy;
	wire ld = tk && !cpu_req[1].we;
	wire st = tk && cpu_req[1].we;
	always_ff @(posedge pclk) begin
		if (tk) begin
			va_q <= cpu_req[1].vaddr;
			pa_q <= cpu_req[1].paddr;
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ----
	// sequences
	// ----
	sequence s_walk;
		spr_req[1].idx_vld ##1 spr_req[1].tag_vld;
	endsequence
	sequence s_ld_hit;
		ld ##2 spr_rsp[1].hit;
	endsequence
	sequence s_st_hit;
		st ##2 spr_rsp[1].hit;
	endsequence
	// ----
	// assertions
	// ----
	a_apb_wait:
		assert property (psel && penable && !pready |=> pready)
		else $error("apb access not answered next cycle");
	a_apb_pulse:
		assert property (pready |=> !pready)
		else $error("pready held over one cycle");
	a_apb_err:
		assert property (pready |-> pslverr ==
			(paddr != 12'h000 && paddr != 12'h004))
		else $error("pslverr wrong for address");
	a_spr_walk:
		assert property (tk && !cpu_req[1].uncached |=> s_walk)
		else $error("scratchpad index and tag out of step");
	a_spr_index:
		assert property (spr_req[1].idx_vld |-> spr_req[1].idx == va_q[19:0])
		else $error("scratchpad index not from virtual address");
	a_phys_tag:
		assert property (spr_req[1].tag_vld |-> spr_req[1].tag == pa_q[31:10])
		else $error("tag not from physical address");
	a_spr_ack:
		assert property (s_ld_hit |=> cpu_rsp[1].ack &&
			cpu_rsp[1].rdata == $past(spr_rsp[1].rdata))
		else $error("scratchpad hit not answered in third cycle");
	a_spr_no_wt:
		assert property (s_st_hit |-> !(mem_req.vld && mem_req.we) [*4])
		else $error("write-through on scratchpad store hit");
	a_unc_store:
		assert property (st && cpu_req[1].uncached |-> ##[1:40] mem_req.vld &&
			mem_req.we && mem_req.addr[31:2] == pa_q[31:2])
		else $error("uncached store not sent to memory");
	a_mem_hold:
		assert property (mem_req.vld && !mem_rsp.ack |=>
			mem_req.vld && $stable(mem_req.addr))
		else $error("memory request dropped before answer");
	a_cm_reply:
		assert property (cm_ack[1] |-> $past(cm_req.vld) && $past(cm_req.side))
		else $error("maintenance ack without request");
endmodule : csc_ctrl_monitor
`default_nettype wire

// ### csc_mem_model.sv
// csc_mem_model: bus unit memory and scratchpad RAMs behind the controller
// assumes word-aligned byte addresses on the memory request
`timescale 1ns/1ns
`default_nettype none
module csc_mem_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// bus unit
	input wire csc_pkg::csc_mem_req_s mem_req,
	output csc_pkg::csc_mem_rsp_s mem_rsp,
	input wire logic slow,
	output int rd_cnt,
	output int wr_cnt,
	// scratchpads
	input wire csc_pkg::csc_spr_req_s [1:0] spr_req,
	output csc_pkg::csc_spr_rsp_s [1:0] spr_rsp
);
	import csc_pkg::*;
	logic [1:0] k_q;
	logic gap_q;
	logic [31:0] cyc_q;
	logic [3:0] ix_q [2];
	logic [31:0] ram_q [2][16];
	wire [31:0] wa = {mem_req.addr[31:4], mem_req.addr[3:2] + k_q, 2'h0};
	always_comb begin
		for (int s = 0; s < 2; s++) begin
			spr_rsp[s].hit = spr_req[s].tag_vld && spr_req[s].tag[21:10] == 12'h800;
			spr_rsp[s].rdata = spr_rsp[s].hit ? ram_q[s][ix_q[s]] : cyc_q;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{mem_rsp, k_q, gap_q, cyc_q, rd_cnt, wr_cnt} <= '0;
			ram_q <= '{default: 32'h5A5A_0000};
		end else begin
			cyc_q <= cyc_q + 32'h1;
			mem_rsp.ack <= 1'b0;
			mem_rsp.rdata <= ~mem_rsp.rdata;
			gap_q <= slow & ~gap_q;
			// wrapped burst from the missed word
			if (mem_req.vld && !mem_rsp.ack && !gap_q) begin
				mem_rsp.ack <= 1'b1;
				mem_rsp.rdata <= wa ^ 32'hA5A5_A5A5;
				k_q <= mem_req.burst ? k_q + 2'h1 : 2'h0;
				if (mem_req.we) wr_cnt <= wr_cnt + 1;
				else if (k_q == 2'h0) rd_cnt <= rd_cnt + 1;
			end
			for (int s = 0; s < 2; s++) begin
				if (spr_req[s].idx_vld) ix_q[s] <= spr_req[s].idx[19:16];
				if (spr_rsp[s].hit && spr_req[s].we) ram_q[s][ix_q[s]] <= spr_req[s].wdata;
			end
		end
	end
endmodule : csc_mem_model
`default_nettype wire

// ### tb_csc_ctrl.sv
// tb_csc_ctrl: self-checking bench for the cache controller
// assumes csc_pkg, csc_ctrl, csc_mem_model, csc_ctrl_monitor compiled first
`timescale 1ns/1ns
`default_nettype none
`include "csc_map.svh"
module tb_csc_ctrl;
	import csc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	csc_req_s [1:0] cpu_req;
	csc_rsp_s [1:0] cpu_rsp;
	csc_cm_s cm_req;
	logic [1:0] cm_ack;
	csc_mem_req_s mem_req;
	csc_mem_rsp_s mem_rsp;
	csc_spr_req_s [1:0] spr_req;
	csc_spr_rsp_s [1:0] spr_rsp;
	int rd_cnt, wr_cnt, err_total, cmp_count;
	csc_ctrl #(.D_SPR(1'b1)) dut_u (.*);
	csc_mem_model u_mem (.*);
	// ----
	// helpers
	// ----
	task automatic give_verdict;
		if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic tmo(input bit t);
		if (t) begin
			err_total++;
			give_verdict();
		end
	endtask : tmo
	task automatic chk(input string nm, input logic [31:0] s, x);
		cmp_count++;
		if (s !== x) begin
			err_total++;
			$display("CHECK FAILED %s exp %h seen %h", nm, x, s);
		end
	endtask : chk
	function automatic logic [31:0] fm(input logic [31:0] a);
		return a ^ 32'hA5A5_A5A5;
	endfunction : fm
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 60);
		{psel, penable} <= 2'h0;
		r = prdata;
		e = pslverr;
		tmo(n > 59);
	endtask : apb
	task automatic op(input int sd, input logic w, u, input logic [31:0] va,
		pa, d, output logic [31:0] r, output int l);
		int n;
		@(posedge pclk);
		cpu_req[sd] <= '{1'b1, w, u, 4'hF, va, pa, d};
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (cpu_rsp[sd].rdy !== 1'b1 && n < 60);
		cpu_req[sd].vld <= 1'b0;
		l = 0;
		do begin
			@(posedge pclk);
			l++;
		end while (cpu_rsp[sd].ack !== 1'b1 && l < 60);
		r = cpu_rsp[sd].rdata;
		tmo(n > 59 || l > 59);
	endtask : op
	task automatic cmq(input logic lk, input logic [31:0] a);
		int n;
		@(posedge pclk);
		cm_req <= '{1'b1, 1'b1, lk, a, a};
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (cm_ack[1] !== 1'b1 && n < 60);
		cm_req.vld <= 1'b0;
		tmo(n > 59);
	endtask : cmq
	// ----
	// scenarios
	// ----
	task automatic t_regs;
		logic [31:0] r;
		logic e;
		apb(0, `CSC_CTRL_OFS, 0, r, e);
		chk("ctrl_reset", r, `CSC_CTRL_RST);
		apb(0, `CSC_STAT_OFS, 0, r, e);
		chk("stat_idle", r, 32'h0);
		chk("stat_err", e, 1'b0);
		apb(1, `CSC_CTRL_OFS, 32'h1, r, e);
		apb(0, `CSC_CTRL_OFS, 0, r, e);
		chk("ctrl_write", r, 32'h1);
		apb(1, `CSC_CTRL_OFS, 32'h3, r, e);
		apb(0, 12'h008, 0, r, e);
		chk("unmapped_err", e, 1'b1);
		chk("unmapped_data", r, 32'h0);
	endtask : t_regs
	task automatic t_miss;
		logic [31:0] r;
		int l, c;
		c = rd_cnt;
		op(1, 0, 0, 32'h1100, 32'h1100, 0, r, l);
		chk("miss_data", r, fm(32'h1100));
		op(1, 0, 0, 32'h1104, 32'h1104, 0, r, l);
		chk("line_word", r, fm(32'h1104));
		op(1, 0, 0, 32'h1100, 32'h1100, 0, r, l);
		chk("hit_lat", l, 3);
		chk("hit_reads", rd_cnt, c + 1);
	endtask : t_miss
	task automatic t_store;
		logic [31:0] r;
		int l, c, d;
		c = wr_cnt;
		d = rd_cnt;
		op(1, 1, 0, 32'h1108, 32'h1108, 32'h0BAD_F00D, r, l);
		op(1, 0, 0, 32'h1108, 32'h1108, 0, r, l);
		chk("hit_update", r, 32'h0BAD_F00D);
		op(1, 1, 0, 32'h5500, 32'h5500, 32'h1234_5678, r, l);
		chk("wt_count", wr_cnt, c + 2);
		op(1, 0, 0, 32'h5500, 32'h5500, 0, r, l);
		chk("no_alloc", r, fm(32'h5500));
		chk("no_alloc_rd", rd_cnt, d + 1);
	endtask : t_store
	task automatic t_unc;
		logic [31:0] r;
		int l, c;
		slow <= 1'b1;
		c = rd_cnt;
		op(1, 0, 1, 32'h1108, 32'h1108, 0, r, l);
		chk("unc_read", r, fm(32'h1108));
		op(1, 1, 1, 32'h1108, 32'h1108, 32'h7777_7777, r, l);
		op(1, 0, 0, 32'h1108, 32'h1108, 0, r, l);
		chk("unc_keep", r, 32'h0BAD_F00D);
		chk("unc_reads", rd_cnt, c + 1);
		slow <= 1'b0;
	endtask : t_unc
	task automatic t_spr;
		logic [31:0] r;
		int l, c, w;
		c = rd_cnt;
		w = wr_cnt;
		op(1, 0, 0, 32'h0004_5670, 32'h8000_0670, 0, r, l);
		chk("spr_data", r, 32'h5A5A_0000);
		chk("spr_lat", l, 3);
		op(1, 1, 0, 32'h0004_5670, 32'h8000_0670, 32'hC0DE_0001, r, l);
		op(1, 0, 0, 32'h0004_5670, 32'h8000_0670, 0, r, l);
		chk("spr_store", r, 32'hC0DE_0001);
		op(1, 0, 0, 32'h000C_5670, 32'h8000_0670, 0, r, l);
		chk("spr_far_idx", r, 32'h5A5A_0000);
		chk("spr_no_fill", rd_cnt, c);
		chk("spr_no_wt", wr_cnt, w);
	endtask : t_spr
	task automatic t_lock;
		logic [31:0] r;
		int l, c;
		op(1, 0, 0, 32'h0200, 32'h0200, 0, r, l);
		cmq(1, 32'h0200);
		for (int i = 1; i < 6; i++) begin
			op(1, 0, 0, {i[15:0], 16'h0200}, {i[15:0], 16'h0200}, 0, r, l);
		end
		c = rd_cnt;
		op(1, 0, 0, 32'h0200, 32'h0200, 0, r, l);
		chk("lock_kept", rd_cnt, c);
		chk("lock_data", r, fm(32'h0200));
		cmq(0, 32'h0200);
	endtask : t_lock
	task automatic t_both;
		logic [31:0] r, s;
		logic e;
		int l, m, c;
		slow <= 1'b1;
		c = rd_cnt;
		fork
			op(0, 0, 0, 32'h3000, 32'h3000, 0, r, l);
			op(1, 0, 0, 32'h1100, 32'h1100, 0, s, m);
		join
		chk("fetch_miss", r, fm(32'h3000));
		chk("load_par", s, fm(32'h1100));
		chk("load_lat", m, 3);
		op(0, 0, 0, 32'h3004, 32'h3004, 0, r, l);
		chk("fill_bypass", r, fm(32'h3004));
		chk("fill_reads", rd_cnt, c + 1);
		// a disabled data cache misses even on a resident line
		apb(1, `CSC_CTRL_OFS, 32'h1, r, e);
		c = rd_cnt;
		op(1, 0, 0, 32'h1100, 32'h1100, 0, r, l);
		chk("off_data", r, fm(32'h1100));
		chk("off_miss", rd_cnt, c + 1);
		apb(1, `CSC_CTRL_OFS, 32'h3, r, e);
		slow <= 1'b0;
	endtask : t_both
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
		{cpu_req, cm_req, err_total, cmp_count} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_miss();
		t_store();
		t_unc();
		t_spr();
		t_lock();
		t_both();
		give_verdict();
	end
endmodule : tb_csc_ctrl
bind csc_ctrl csc_ctrl_monitor u_mon (.*);
`default_nettype wire
